// ===== src/isa_memory_command_control.sv
// isa memory command, byte-high, 16-bit select and master handover control
`timescale 1ns/10ps

module isa_memory_command_control #(
  parameter logic [3:0] CMD_LEN = isa_mem_pkg::CMD_CLKS    // command pulse length, clocks
) (
  input  wire logic                    clk,               // isa system clock
  input  wire logic                    rst_b,             // sync reset, active low
  input  wire logic                    req_valid,         // core offers a cycle
  input  wire isa_mem_pkg::cycle_req_t req,               // the offered cycle
  output logic                         req_ready,         // cycle taken this clock
  output logic                         cyc_done,          // last command clock, pulse
  output logic                         mem16_q,           // last memory cycle was 16-bit
  output logic                         swap_q,            // dma byte swap steer
  output logic                         master_own,        // external master holds bus
  input  wire logic                    master_n,          // external master request pin
  input  wire logic                    dack_grant,        // acknowledge active on master channel
  input  wire logic [23:0]             master_addr,       // address seen from external master
  input  wire logic                    pci_mem_hit,       // master address decodes to pci memory
  input  wire logic                    memr_n_i,          // read command pin in
  output logic                         memr_n_o,          // read command pin out
  output logic                         memr_n_oe,         // read command drive enable
  input  wire logic                    memw_n_i,          // write command pin in
  output logic                         memw_n_o,          // write command pin out
  output logic                         memw_n_oe,         // write command drive enable
  input  wire logic                    sbhe_n_i,          // byte high enable pin in
  output logic                         sbhe_n_o,          // byte high enable pin out
  output logic                         sbhe_n_oe,         // byte high enable drive enable
  output logic                         master_hi_q,       // master moves upper byte
  input  wire logic                    memcs16_n_i,       // 16-bit select pin in
  output logic                         memcs16_n_o,       // 16-bit select pin out, always low
  output logic                         memcs16_n_oe,      // 16-bit select pull enable
  output logic                         smemr_n,           // system read strobe
  output logic                         smemw_n            // system write strobe
);

  // ************************************************************
  // state and latched request
  // ************************************************************
  isa_mem_pkg::seq_state_t state_q, state_d;               // sequencer
  isa_mem_pkg::cycle_req_t req_q, req_nx;                  // cycle in flight
  logic [isa_mem_pkg::CNT_W-1:0] cnt_q, cnt_d;             // command clocks left
  logic memr_q, memr_d;                                    // read command active
  logic memw_q, memw_d;                                    // write command active
  logic sbhe_q, sbhe_d;                                    // byte high active
  logic cs16_pull_q;                                       // pulling 16-bit select
  logic mem16_d, swap_d;                                   // sampled select results
  logic own_q;                                             // bus held by external master
  logic granted_q;                                         // acknowledge seen for master

  // ************************************************************
  // ownership
  // ************************************************************
  // an external master may only claim after its acknowledge; the
  // grant flag keeps a stray low on the pin from stealing the bus
  wire claim    = !master_n && (granted_q || dack_grant);
  assign master_own = own_q;

  // ownership lasts until the master releases its pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      own_q     <= 1'b0;
      granted_q <= 1'b0;
    end else begin
      own_q     <= claim && (state_d == isa_mem_pkg::ST_IDLE || own_q);
      granted_q <= dack_grant || (granted_q && !master_n && own_q);
    end
  end

  // ************************************************************
  // request acceptance and decode
  // ************************************************************
  wire idle     = (state_q == isa_mem_pkg::ST_IDLE);
  assign req_ready = idle && !own_q && !claim;
  wire take     = req_valid && req_ready;
  assign req_nx = take ? req : req_q;

  // address regions of the cycle about to run
  wire below_16m = (req_nx.addr < isa_mem_pkg::FULL_LIMIT);
  wire below_1m  = (req_nx.addr < isa_mem_pkg::LOW_MEG_LIMIT);

  // which kinds are allowed to raise a memory command
  wire k_mem  = (req_nx.kind == isa_mem_pkg::KIND_MEM);
  wire k_ref  = (req_nx.kind == isa_mem_pkg::KIND_REFRESH);
  wire k_cmp  = (req_nx.kind == isa_mem_pkg::KIND_DMA_CMP);
  wire k_fst  = (req_nx.kind == isa_mem_pkg::KIND_DMA_FST);
  wire k_io   = (req_nx.kind == isa_mem_pkg::KIND_IO);

  // fast dma never raises a command; compatible dma stops at 16m
  wire rd_ok  = !k_fst && (k_ref || k_mem || (k_cmp && below_16m));
  wire wr_ok  = !k_fst && !k_ref && (k_mem || (k_cmp && below_16m));

  // ************************************************************
  // sequencer
  // ************************************************************
  // idle -> cmd for CMD_LEN clocks -> one clock of recovery
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      isa_mem_pkg::ST_IDLE: begin
        if (take) begin
          state_d = isa_mem_pkg::ST_CMD;
          cnt_d   = CMD_LEN;
        end
      end
      isa_mem_pkg::ST_CMD: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1'b1) begin
          state_d = isa_mem_pkg::ST_END;
        end
      end
      isa_mem_pkg::ST_END: begin
        state_d = isa_mem_pkg::ST_IDLE;
      end
      default: begin
        state_d = isa_mem_pkg::ST_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  wire in_cmd_d = (state_d == isa_mem_pkg::ST_CMD);
  assign cyc_done = (state_q == isa_mem_pkg::ST_CMD) && (cnt_q == 1'b1);

  // command levels for the next clock, registered below
  // refresh always reads, whatever the write flag of the request says
  assign memr_d = in_cmd_d && (!req_nx.write || k_ref) && rd_ok;
  assign memw_d = in_cmd_d && req_nx.write && wr_ok;
  assign sbhe_d = in_cmd_d && req_nx.hi_byte && !k_ref;

  // ************************************************************
  // 16-bit select sampling
  // ************************************************************
  // sampled on the last command clock: i/o and refresh ignore it,
  // dma only steers the swap, and nothing here changes cycle length
  wire cs16 = !memcs16_n_i;
  assign mem16_d = (cyc_done && k_mem && !k_io && !k_ref) ? cs16 : mem16_q;
  assign swap_d  = (cyc_done && (k_cmp || k_fst)) ? cs16 : swap_q;

  // ************************************************************
  // sequencer and command registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= isa_mem_pkg::ST_IDLE;
      cnt_q   <= '0;
      req_q   <= '0;
      memr_q  <= 1'b0;
      memw_q  <= 1'b0;
      sbhe_q  <= 1'b0;
      mem16_q <= 1'b0;
      swap_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      req_q   <= req_nx;
      memr_q  <= memr_d;
      memw_q  <= memw_d;
      sbhe_q  <= sbhe_d;
      mem16_q <= mem16_d;
      swap_q  <= swap_d;
    end
  end

  // ************************************************************
  // pins owned while the bridge is master
  // ************************************************************
  // lines float whenever the external master holds the bus
  assign memr_n_oe = !own_q;
  assign memw_n_oe = !own_q;
  assign sbhe_n_oe = !own_q;
  assign memr_n_o  = !memr_q;
  assign memw_n_o  = !memw_q;
  assign sbhe_n_o  = !sbhe_q;

  // ************************************************************
  // 16-bit select as open drain
  // ************************************************************
  // input while the bridge owns; pulled only for master-to-pci memory.
  // slaves drive it from the unlatched address, so the pull follows
  // the address decode and not the command strobes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs16_pull_q <= 1'b0;
      master_hi_q <= 1'b0;
    end else begin
      cs16_pull_q <= own_q && claim && pci_mem_hit;
      master_hi_q <= own_q && !sbhe_n_i;
    end
  end
  assign memcs16_n_oe = cs16_pull_q;
  assign memcs16_n_o  = isa_mem_pkg::PIN_ACTIVE;

  // ************************************************************
  // system memory strobes
  // ************************************************************
  // only below 1m; between 1m and 16m the full commands run alone
  wire m_low   = (master_addr < isa_mem_pkg::MASTER_LOW_LIM);
  wire dev_low = (req_q.addr < isa_mem_pkg::LOW_MEG_LIMIT);
  wire dev_smr = memr_q && dev_low && (req_q.kind != isa_mem_pkg::KIND_REFRESH);
  wire src_rd  = own_q ? (!memr_n_i && m_low) : dev_smr;
  wire src_wr  = own_q ? (!memw_n_i && m_low) : (memw_q && dev_low);

  // delayed copies, reset to idle high
  strobe_delay #(
    .DEPTH (isa_mem_pkg::STROBE_DELAY)
  ) u_smemr (
    .clk      (clk),
    .rst_b    (rst_b),
    .cmd_n    (!src_rd),
    .strobe_n (smemr_n)
  );

  strobe_delay #(
    .DEPTH (isa_mem_pkg::STROBE_DELAY)
  ) u_smemw (
    .clk      (clk),
    .rst_b    (rst_b),
    .cmd_n    (!src_wr),
    .strobe_n (smemw_n)
  );

  // ************************************************************
  // checks
  // ************************************************************
  a_refresh_no_sbhe: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state_q == isa_mem_pkg::ST_CMD && req_q.kind == isa_mem_pkg::KIND_REFRESH)
      |-> sbhe_n_o && !memr_n_o)
    else $error("byte high or read wrong in refresh");

  a_float_when_master: assert property (
    @(posedge clk) disable iff (!rst_b)
    own_q |-> !memr_n_oe && !memw_n_oe && !sbhe_n_oe)
    else $error("command lines driven while master owns");

  a_master_holds_bus: assert property (
    @(posedge clk) disable iff (!rst_b)
    (own_q && !master_n) |=> own_q && req_ready == 1'b0)
    else $error("ownership lost before master released");

  a_fast_dma_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    (req_q.kind == isa_mem_pkg::KIND_DMA_FST) |-> memr_n_o && memw_n_o)
    else $error("command during fast dma");

  a_compat_high_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    (req_q.kind == isa_mem_pkg::KIND_DMA_CMP && req_q.addr >= isa_mem_pkg::FULL_LIMIT)
      |-> memr_n_o && memw_n_o)
    else $error("compatible dma command above 16m");

  a_sbhe_follows: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state_q == isa_mem_pkg::ST_CMD && req_q.kind == isa_mem_pkg::KIND_MEM)
      |-> sbhe_n_o == !req_q.hi_byte)
    else $error("byte high does not match upper byte");

  a_strobe_lags_cmd: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($fell(smemr_n) && !$past(own_q)) |-> $past(memr_q) && $past(dev_low))
    else $error("read strobe not behind read command");

  a_mid_region_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!own_q && memw_q && !dev_low) |=> smemw_n)
    else $error("write strobe above 1m");

  a_low_write_strobe: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!own_q && memw_q && dev_low) |=> !smemw_n)
    else $error("write strobe missing below 1m");

  a_reset_strobe_high: assert property (
    @(posedge clk) disable iff (!rst_b)
    !$past(rst_b) |-> smemw_n && smemr_n)
    else $error("system strobe low after reset");

  a_pull_only_pci: assert property (
    @(posedge clk) disable iff (!rst_b)
    memcs16_n_oe |-> $past(own_q) && $past(pci_mem_hit))
    else $error("16-bit select pulled without master pci hit");

endmodule : isa_memory_command_control

// ===== src/isa_mem_pkg.sv
// shared constants and carrier types for the isa memory command control
package isa_mem_pkg;

  // ************************************************************
  // address limits
  // ************************************************************
  localparam logic [31:0] LOW_MEG_LIMIT  = 32'h0010_0000;  // 1 mbyte, system strobe region
  localparam logic [31:0] FULL_LIMIT     = 32'h0100_0000;  // 16 mbyte, isa reach
  localparam logic [23:0] MASTER_LOW_LIM = 24'h10_0000;    // 1 mbyte seen on 24-bit master addr

  // ************************************************************
  // timing counts, in isa clocks
  // ************************************************************
  localparam int          CNT_W          = 4;              // command counter width
  localparam logic [3:0]  CMD_CLKS       = 4'h3;           // command pulse length
  localparam int          STROBE_DELAY   = 1;              // system strobe lag behind command

  // ************************************************************
  // pin levels
  // ************************************************************
  localparam logic        PIN_IDLE       = 1'b1;           // active-low lines at rest
  localparam logic        PIN_ACTIVE     = 1'b0;           // active-low lines asserted

  // ************************************************************
  // cycle kinds and sequencer states
  // ************************************************************
  typedef enum logic [4:0] {
    KIND_MEM     = 5'b00001,                               // device-mastered memory cycle
    KIND_IO      = 5'b00010,                               // device-mastered i/o cycle
    KIND_REFRESH = 5'b00100,                               // refresh cycle
    KIND_DMA_CMP = 5'b01000,                               // compatible-timing dma
    KIND_DMA_FST = 5'b10000                                // fast dma, timing type a, b or f
  } cycle_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,                                      // waiting for a request
    ST_CMD  = 3'b010,                                      // command lines active
    ST_END  = 3'b100                                       // one clock of recovery
  } seq_state_t;

  // one cycle request from the bridge core
  typedef struct packed {
    cycle_kind_t kind;                                     // which kind of cycle
    logic        write;                                    // 1 write, 0 read
    logic        hi_byte;                                  // upper data byte moves
    logic [31:0] addr;                                     // target byte address
  } cycle_req_t;

endpackage : isa_mem_pkg

// ===== src/strobe_delay.sv
// delay line that derives a system memory strobe from a command
`timescale 1ns/10ps

module strobe_delay #(
  parameter int DEPTH = isa_mem_pkg::STROBE_DELAY        // clocks of lag
) (
  input  wire logic clk,                                   // isa clock
  input  wire logic rst_b,                                 // sync reset, active low
  input  wire logic cmd_n,                                 // active-low qualified command
  output logic      strobe_n                               // delayed active-low strobe
);

  // ************************************************************
  // shift chain
  // ************************************************************
  logic [DEPTH:0] chain;                                   // stage 0 is the live command

  assign chain[0] = cmd_n;

  // each stage rests high so the strobe sits idle in reset
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      logic stage_q;                                       // one clock of lag
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          stage_q <= isa_mem_pkg::PIN_IDLE;
        end else begin
          stage_q <= chain[g];
        end
      end
      assign chain[g+1] = stage_q;
    end
  endgenerate

  // output from the last flip-flop whenever DEPTH is 1 or more, never ahead of the command
  assign strobe_n = chain[DEPTH];

endmodule : strobe_delay

// ===== testbench/isa_far_side.sv
// model of the isa slots: a 16-bit memory slave and an external bus master
`timescale 1ns/10ps

module isa_far_side #(
  parameter logic [6:0] SLAVE16_TOP = 7'h08          // slave answers 16-bit below this la
) (
  input  wire logic       clk,                       // isa clock
  input  wire logic [6:0] la,                        // unlatched upper address on the bus
  input  wire logic       go,                        // master wants the bus
  input  wire logic       dack_grant,                // acknowledge seen by the master
  input  wire logic [2:0] ext_cmd_n,                 // master drive: read, write, byte high
  output logic            master_n,                  // master request pin
  input  wire logic [2:0] dut_o,                     // bridge drive: read, write, byte high
  input  wire logic [2:0] dut_oe,                    // bridge enables, same order
  input  wire logic       cs_o,                      // bridge 16-bit select level
  input  wire logic       cs_oe,                     // bridge 16-bit select pull
  output logic [2:0]      line_n,                    // resolved read, write, byte high
  output logic            cs16_n                     // resolved 16-bit select
);
  // ************************************************************
  // bus lines
  // ************************************************************
  logic [2:0] own_drv;                               // what the master puts on the lines

  initial master_n = 1'b1;

  // the master raises its request only once it has seen its acknowledge
  always @(posedge clk) begin
    master_n <= !(go && (dack_grant || !master_n));
  end

  // master drives only while holding the bus, otherwise the pull-ups win
  assign own_drv = master_n ? 3'b111 : ext_cmd_n;
  assign line_n  = (dut_o | ~dut_oe) & own_drv;
  // decode from the unlatched address alone, no command qualifies it
  assign cs16_n  = ~((cs_oe & ~cs_o) | (la < SLAVE16_TOP));
endmodule : isa_far_side

// ===== testbench/testbench.sv
// self-checking testbench for the isa memory command control
`timescale 1ns/10ps

module testbench;
  // ************************************************************
  // signals
  // ************************************************************
  logic                    clk;                      // isa clock
  logic                    rst_b;                    // sync reset, active low
  logic                    req_valid;                // cycle offer
  isa_mem_pkg::cycle_req_t req;                      // offered cycle
  logic                    req_ready, cyc_done, mem16_q, swap_q, master_own;
  logic                    master_n, dack_grant, pci_mem_hit, master_hi_q;
  logic [23:0]             master_addr;              // external master address
  logic                    memr_n_o, memr_n_oe, memw_n_o, memw_n_oe, sbhe_n_o, sbhe_n_oe;
  logic                    memcs16_n_o, memcs16_n_oe, smemr_n, smemw_n, cs16_n, ext_go;
  logic [2:0]              line_n;                   // resolved read, write, byte high
  logic [2:0]              ext_cmd_n;                // master command drive
  logic [6:0]              la;                       // unlatched address on the bus
  int                      bad_count;                // mismatches
  int                      samples_checked;          // comparisons

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // bus address comes from whoever holds the bus
  assign la = master_own ? master_addr[23:17] : req.addr[23:17];

  isa_memory_command_control i_dut (
    .clk, .rst_b, .req_valid, .req, .req_ready, .cyc_done, .mem16_q, .swap_q, .master_own,
    .master_n, .dack_grant, .master_addr, .pci_mem_hit, .master_hi_q,
    .memr_n_i(line_n[2]), .memr_n_o, .memr_n_oe, .memw_n_i(line_n[1]), .memw_n_o,
    .memw_n_oe, .sbhe_n_i(line_n[0]), .sbhe_n_o, .sbhe_n_oe, .memcs16_n_i(cs16_n),
    .memcs16_n_o, .memcs16_n_oe, .smemr_n, .smemw_n
  );

  isa_far_side i_far (
    .clk, .la, .go(ext_go), .dack_grant, .ext_cmd_n, .master_n,
    .dut_o({memr_n_o, memw_n_o, sbhe_n_o}), .dut_oe({memr_n_oe, memw_n_oe, sbhe_n_oe}),
    .cs_o(memcs16_n_o), .cs_oe(memcs16_n_oe), .line_n, .cs16_n
  );

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic seen, input logic exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t %s: saw %b want %b", $time, what, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // one bridge cycle; expected command and strobe activity given as active-high flags
  task automatic run_cycle(input isa_mem_pkg::cycle_kind_t k, input logic wr, hi,
                           input logic [31:0] a, input logic er, ew, esr, esw);
    int n;
    n = 0;
    req = '{kind: k, write: wr, hi_byte: hi, addr: a};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check(req_ready, 1'b1, "cycle accepted");
    tick(1);
    req_valid = 1'b0;
    check(memr_n_o, !er, "read command");
    check(memw_n_o, !ew, "write command");
    // strobes lag the command, so nothing yet
    check(smemr_n, 1'b1, "read strobe early");
    check(smemw_n, 1'b1, "write strobe early");
    if (k != isa_mem_pkg::KIND_IO && k != isa_mem_pkg::KIND_DMA_FST)
      check(sbhe_n_o, !(hi && k != isa_mem_pkg::KIND_REFRESH), "byte high");
    tick(1);
    check(smemr_n, !esr, "read strobe");
    check(smemw_n, !esw, "write strobe");
    n = 0;
    while (cyc_done !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    // the select must never stretch a cycle: last clock comes at a fixed count
    check(n == int'(isa_mem_pkg::CMD_CLKS) - 2, 1'b1, "command length");
    check(memr_n_o, !er, "read held");
    tick(2);
  endtask : run_cycle

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    tick(1);
    check(smemw_n, 1'b1, "write strobe in reset");
    check(memr_n_oe, 1'b1, "read drive in reset");
    check(memcs16_n_oe, 1'b0, "select pull in reset");
    tick(1);
    rst_b = 1'b1;
  endtask : t_reset

  task automatic t_device_mem;
    run_cycle(isa_mem_pkg::KIND_MEM, 1'b1, 1'b1, 32'h0020_0000, 0, 1, 0, 0);
    check(mem16_q, 1'b0, "8-bit slave");
    run_cycle(isa_mem_pkg::KIND_MEM, 1'b0, 1'b1, 32'h000f_fffe, 1, 0, 1, 0);
    check(mem16_q, 1'b1, "16-bit slave");
    run_cycle(isa_mem_pkg::KIND_MEM, 1'b1, 1'b0, 32'h0000_1000, 0, 1, 0, 1);
  endtask : t_device_mem

  task automatic t_refresh_io;
    run_cycle(isa_mem_pkg::KIND_MEM, 1'b0, 1'b0, 32'h0030_0000, 1, 0, 0, 0);
    run_cycle(isa_mem_pkg::KIND_REFRESH, 1'b0, 1'b1, 32'h0, 1, 0, 0, 0);
    check(mem16_q, 1'b0, "refresh ignores select");
    run_cycle(isa_mem_pkg::KIND_IO, 1'b0, 1'b0, 32'h0, 0, 0, 0, 0);
    check(mem16_q, 1'b0, "io ignores select");
  endtask : t_refresh_io

  task automatic t_dma;
    run_cycle(isa_mem_pkg::KIND_DMA_CMP, 1'b0, 1'b0, 32'h0, 1, 0, 1, 0);
    check(swap_q, 1'b1, "swap from select");
    check(mem16_q, 1'b0, "dma leaves width");
    run_cycle(isa_mem_pkg::KIND_DMA_CMP, 1'b1, 1'b0, 32'h00ff_fffe, 0, 1, 0, 0);
    check(swap_q, 1'b0, "no swap");
    run_cycle(isa_mem_pkg::KIND_DMA_CMP, 1'b0, 1'b1, 32'h0100_0000, 0, 0, 0, 0);
    run_cycle(isa_mem_pkg::KIND_DMA_CMP, 1'b1, 1'b0, 32'h0200_0000, 0, 0, 0, 0);
    run_cycle(isa_mem_pkg::KIND_DMA_FST, 1'b0, 1'b0, 32'h0, 0, 0, 0, 0);
    run_cycle(isa_mem_pkg::KIND_DMA_FST, 1'b1, 1'b0, 32'h0, 0, 0, 0, 0);
  endtask : t_dma

  task automatic t_master;
    int n;
    n = 0;
    master_addr = 24'h00_4000;
    pci_mem_hit = 1'b1;
    ext_go = 1'b1;
    tick(3);
    check(master_own, 1'b0, "no takeover before grant");
    dack_grant = 1'b1;
    while (master_own !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    check(master_own, 1'b1, "master owns");
    check(memr_n_oe, 1'b0, "read released");
    check(memw_n_oe, 1'b0, "write released");
    check(sbhe_n_oe, 1'b0, "byte high released");
    check(req_ready, 1'b0, "core refused");
    tick(1);
    check(memcs16_n_oe, 1'b1, "select pulled for pci");
    ext_cmd_n = 3'b010;
    tick(2);
    check(smemr_n, 1'b0, "master read strobe");
    check(master_hi_q, 1'b1, "master byte high");
    ext_cmd_n = 3'b111;
    master_addr = 24'h20_0000;
    pci_mem_hit = 1'b0;
    tick(2);
    ext_cmd_n = 3'b101;
    tick(2);
    check(smemw_n, 1'b1, "no strobe above 1m");
    check(memcs16_n_oe, 1'b0, "no pull off pci");
    master_addr = 24'h00_0100;
    tick(2);
    check(smemw_n, 1'b0, "master write strobe");
    ext_cmd_n = 3'b111;
    ext_go = 1'b0;
    dack_grant = 1'b0;
    tick(4);
    check(master_own, 1'b0, "bus returned");
    check(memr_n_oe, 1'b1, "read driven again");
  endtask : t_master

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    dack_grant = 1'b0;
    master_addr = 24'h00_0000;
    pci_mem_hit = 1'b0;
    ext_go = 1'b0;
    ext_cmd_n = 3'b111;
    bad_count = 0;
    samples_checked = 0;
    t_reset();
    t_device_mem();
    t_refresh_io();
    t_dma();
    t_master();
    test_done();
  end

  // far longer than the roughly 80 clocks the scenarios need
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule : testbench
